// >>> rtl/status_reg_write_protect.sv
// Purpose: quad-I/O enable and status register write protection of a serial flash
// Assumes: commands arrive decoded, one pulse per completed command
// Notes:   pins pass a three stage synchroniser before use
//          quad mode hands both pins to the data path, so their levels are then ignored
//          protect and quad bits reload on rst and on either reset command alike; only rst clears the pin filters and the quad refusal pulse
//          the permanent lock input is trusted as stable, it is not filtered
// Functional notes
// - quad enable bit turns quad and Execute_in_place_mode on
// - quad mode makes pins data lines 2,3
// - quad bit gates only six quad commands
// - protect 0,0: writes need only write enable
// - protect 0,1, pin low: writes blocked
// - protect 0,1, pin high: writes with enable
// - protect 1,0: locked until reset, then 0,0
// - protect 1,1 unlocked: until reset, then 0,1
// - protect 1,1 locked: permanent, stays 1,1
// - reset copies non-volatile 0,0 or 0,1 unchanged
// - bit0 high protect, bit1 quad, bit2 zero
// - pause/reset select ignored while quad enabled
`timescale 1ns/1ps
`include "sr_params.svh"
module status_reg_write_protect (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  soft_reset,
	// decoded command from the serial front end
	input  wire logic                  cmd_valid,
	input  wire logic [7:0]            cmd_opcode,
	input  wire logic [7:0]            cmd_data,
	input  wire logic                  write_enable_latch,
	// non-volatile copies and lock
	input  wire logic                  nv_protect_hi,
	input  wire logic                  nv_protect_lo,
	input  wire logic                  protect_perm_lock,
	input  wire logic                  hold_reset_select,
	// pins
	input  wire logic                  wp_pin,
	input  wire logic                  hold_reset_pin,
	// register view
	output logic [7:0]                 cfg_read,
	output logic                       reg_protect_hi,
	output logic                       reg_protect_lo,
	// mode outputs
	output logic                       quad_io_enable,
	output logic                       execute_in_place_mode,
	output logic                       io2_is_data,
	output logic                       io3_is_data,
	output logic                       wp_func_active,
	output logic                       hold_func_active,
	output logic                       reset_func_active,
	output logic                       hold_request,
	output logic                       pin_reset_request,
	// protection verdict
	output logic                       status_write_allowed,
	output sr_pkg::prot_mode_type      protect_mode,
	// command results
	output logic                       wr_accept,
	output logic                       wr_reject,
	output logic                       quad_reject,
	output logic                       start_write_cycle
);
	import sr_pkg::*;

	state_type cur;       // registered state
	state_type next_cur;  // value for the next edge
	logic      reset_any; // software or pin reset, same effect as rst on protect bits
	logic      is_wrsr;   // opcode is a write-status command
	logic      is_quad;   // opcode needs quad enable
	logic      accept;    // write-status passes protection and enable

	// protect bits go out to the decoder, the verdict comes back
	prot_if pif ();

	// the table lookup sits in its own module so it reads as one case
	protect_decode u_decode (
		.p (pif.decoder)
	);

	// opcode belongs to the write-status family
	function automatic logic wrsr_op(input logic [7:0] op);
		wrsr_op = (op == `OP_WRITE_SR1) || (op == `OP_WRITE_CFG) ||
		          (op == `OP_WRITE_SR3) || (op == `OP_WRITE_SR_ALT);
	endfunction

	// opcode is one of the quad-gated commands, all others ignore the bit
	function automatic logic quad_op(input logic [7:0] op);
		quad_op = (op == `OP_QUAD_OUT_READ) || (op == `OP_XIP_READ) ||
		          (op == `OP_QUAD_ALIGN_READ) || (op == `OP_QUAD_PROGRAM) ||
		          (op == `OP_BURST_WRAP) || (op == `OP_QUAD_ID);
	endfunction

	// volatile protect value loaded from the non-volatile copy on any reset
	function automatic logic [1:0] reset_protect(input logic hi, input logic lo,
	                                              input logic lock);
		// lockdown 1,0 opens fully; lockdown 1,1 falls back to pin protection
		unique case ({hi, lo})
			2'b00:   reset_protect = 2'b00;
			2'b01:   reset_protect = 2'b01;
			2'b10:   reset_protect = 2'b00;
			default: reset_protect = lock ? 2'b11 : 2'b01;
		endcase
	endfunction

	// feed the decoder from registered bits, except the lock below
	assign pif.protect_hi = cur.protect_hi;
	assign pif.protect_lo = cur.protect_lo;
	// the lock is a non-volatile bit, stable in use, so it goes straight in
	assign pif.perm_lock  = protect_perm_lock;
	assign pif.wp_level   = cur.wp_level;
	assign pif.quad_en    = cur.quad_en;

	// pin functions follow the quad bit
	assign quad_io_enable        = cur.quad_en;
	assign execute_in_place_mode = cur.quad_en;
	assign io2_is_data           = cur.quad_en;
	assign io3_is_data           = cur.quad_en;
	assign wp_func_active        = ~cur.quad_en;
	// selection only counts while the pin is not a data line
	assign hold_func_active  = ~cur.quad_en & ~hold_reset_select;
	assign reset_func_active = ~cur.quad_en & hold_reset_select;
	// a pause or reset request never comes from the pin while quad mode owns it
	// pin is active low in both functions
	assign hold_request      = hold_func_active & ~cur.hold_level;
	assign pin_reset_request = reset_func_active & ~cur.hold_level;

	// register view, reserved and unimplemented bits read zero
	always_comb begin
		// start from all zero so unused bits can never read back stale values
		cfg_read = `CFG_RESET_VALUE;
		cfg_read[`CFG_PROTECT_HI_BIT] = cur.protect_hi;
		cfg_read[`CFG_QUAD_EN_BIT]    = cur.quad_en;
		cfg_read[`CFG_RSVD_BIT]       = 1'b0;
	end

	// plain copies of flip-flops, except the decoder verdict and mode, which are combinational
	assign reg_protect_hi       = cur.protect_hi;
	assign reg_protect_lo       = cur.protect_lo;
	assign status_write_allowed = pif.write_allowed;
	assign protect_mode         = pif.mode;
	assign wr_accept            = cur.wr_accept;
	assign wr_reject            = cur.wr_reject;
	assign quad_reject          = cur.quad_reject;
	assign start_write_cycle    = cur.start_write;

	// command classification
	// accept needs all three: a write opcode, an open protection state and the latch
	assign reset_any = soft_reset | pin_reset_request;
	assign is_wrsr   = cmd_valid & wrsr_op(cmd_opcode);
	assign is_quad   = cmd_valid & quad_op(cmd_opcode);
	assign accept    = is_wrsr & pif.write_allowed & write_enable_latch;

	// next state of every flip-flop
	always_comb begin
		next_cur = cur;
		// the filter costs four edges of latency; the pins are slow, so that is cheap
		// synchronisers: the first stage is read only by the second
		next_cur.wp_sync   = {cur.wp_sync[1:0], wp_pin};
		next_cur.hold_sync = {cur.hold_sync[1:0], hold_reset_pin};
		// a level change counts once the last two stages agree
		if (cur.wp_sync[1] == cur.wp_sync[2]) begin
			next_cur.wp_level = cur.wp_sync[2];
		end
		if (cur.hold_sync[1] == cur.hold_sync[2]) begin
			next_cur.hold_level = cur.hold_sync[2];
		end
		// result pulses last one cycle; a refused write still answers with a pulse
		// so the front end can end the command, but nothing else moves
		next_cur.wr_accept   = accept;
		next_cur.wr_reject   = is_wrsr & ~accept;
		next_cur.start_write = accept;
		next_cur.quad_reject = is_quad & ~cur.quad_en;
		// a reset beats a command taken in the same cycle: the command is dropped
		// and only the quad refusal, which changes no state, may still show
		if (reset_any) begin
			// software or pin reset reloads protect bits, lockdown ends here
			{next_cur.protect_hi, next_cur.protect_lo} =
				reset_protect(nv_protect_hi, nv_protect_lo, protect_perm_lock);
			next_cur.quad_en     = 1'b0;
			next_cur.wr_accept   = 1'b0;
			next_cur.wr_reject   = 1'b0;
			next_cur.start_write = 1'b0;
		end else if (accept) begin
			// only an accepted write touches the bits
			// 11h and 71h reach bits outside this block, so here they only pulse
			if (cmd_opcode == `OP_WRITE_SR1) begin
				next_cur.protect_lo = cmd_data[`SR1_PROTECT_LO_BIT];
			end
			if (cmd_opcode == `OP_WRITE_CFG) begin
				next_cur.protect_hi = cmd_data[`CFG_PROTECT_HI_BIT];
				next_cur.quad_en    = cmd_data[`CFG_QUAD_EN_BIT];
			end
		end
	end

	// one register for all state, synchronous reset
	// the reload reads the non-volatile inputs at the reset edge itself
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur <= next_cur;
			// power or hardware reset: same reload as software reset
			{cur.protect_hi, cur.protect_lo} <=
				reset_protect(nv_protect_hi, nv_protect_lo, protect_perm_lock);
			// quad mode always starts off, it is not kept in the non-volatile copies
			cur.quad_en     <= 1'b0;
			// pins come up released: a low level must pass the filter before it counts,
			// so no false protect or pause follows the reset
			cur.wp_sync     <= 3'h7;
			cur.hold_sync   <= 3'h7;
			cur.wp_level    <= 1'b1;
			cur.hold_level  <= 1'b1;
			cur.wr_accept   <= 1'b0;
			cur.wr_reject   <= 1'b0;
			cur.quad_reject <= 1'b0;
			cur.start_write <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

endmodule

// >>> rtl/sr_params.svh
// Purpose: field positions, reset values and opcodes of the status protect block
// Assumes: included by its bare name from the top module, the assertions and the bench
// Notes:   definitions only
`ifndef SR_PARAMS_SVH
`define SR_PARAMS_SVH

// field positions inside the quad and protect configuration byte
`define CFG_PROTECT_HI_BIT   0
`define CFG_QUAD_EN_BIT      1
`define CFG_RSVD_BIT         2
`define CFG_RESET_VALUE      8'h00

// position of the low protect bit in the byte carried by the first write-status command
`define SR1_PROTECT_LO_BIT   7

// write-status opcodes
`define OP_WRITE_SR1         8'h01
`define OP_WRITE_CFG         8'h31
`define OP_WRITE_SR3         8'h11
`define OP_WRITE_SR_ALT      8'h71

// opcodes that need the quad-I/O enable bit
`define OP_QUAD_OUT_READ     8'h6B
`define OP_XIP_READ          8'hEB
`define OP_QUAD_ALIGN_READ   8'hE7
`define OP_QUAD_PROGRAM      8'h32
`define OP_BURST_WRAP        8'h77
`define OP_QUAD_ID           8'h94

`endif

// >>> rtl/sr_pkg.sv
// Purpose: types shared by the status protect block
// Assumes: nothing
// Notes:   constants live in sr_params.svh
package sr_pkg;

	// protection state resolved from the volatile bits, the lock and the pin
	typedef enum logic [2:0] {
		SW_PROTECTED,
		HW_PROTECTED,
		HW_UNPROTECTED,
		RESET_LOCKDOWN,
		OTP_LOCKED
	} prot_mode_type;

	// every flip-flop of the top module
	typedef struct packed {
		logic       protect_hi;   // volatile high protect bit
		logic       protect_lo;   // volatile low protect bit
		logic       quad_en;      // quad-I/O enable bit
		logic [2:0] wp_sync;      // write-protect pin synchroniser
		logic [2:0] hold_sync;    // pause/reset pin synchroniser
		logic       wp_level;     // filtered write-protect level
		logic       hold_level;   // filtered pause/reset level
		logic       wr_accept;    // write-status accepted pulse
		logic       wr_reject;    // write-status refused pulse
		logic       quad_reject;  // quad command refused pulse
		logic       start_write;  // internal write cycle start pulse
	} state_type;

endpackage

// >>> rtl/prot_if.sv
// Purpose: carries protect bits to the decoder and its verdict back
// Assumes: sr_pkg compiled first
// Notes:   used only between the top module and protect_decode
`timescale 1ns/1ps
interface prot_if;
	import sr_pkg::*;

	logic          protect_hi;     // volatile high protect bit
	logic          protect_lo;     // volatile low protect bit
	logic          perm_lock;      // permanent lock bit
	logic          wp_level;       // filtered write-protect pin, high means released
	logic          quad_en;        // quad mode turns the pin into a data line
	logic          write_allowed;  // status registers may be written
	prot_mode_type mode;           // resolved protection state

	modport decoder (
		input  protect_hi,
		input  protect_lo,
		input  perm_lock,
		input  wp_level,
		input  quad_en,
		output write_allowed,
		output mode
	);

	modport user (
		output protect_hi,
		output protect_lo,
		output perm_lock,
		output wp_level,
		output quad_en,
		input  write_allowed,
		input  mode
	);

endinterface

// >>> rtl/protect_decode.sv
// Purpose: resolves the status register protection state
// Assumes: inputs other than perm_lock come from flip-flops of the same clock
// Notes:   purely combinational
`timescale 1ns/1ps
module protect_decode (
	// protect bits in, verdict out
	prot_if.decoder p
);
	import sr_pkg::*;

	// the pin only protects while it is not a data line
	logic wp_released;  // pin high or pin function disabled

	// decode the protection table
	always_comb begin
		wp_released = p.wp_level | p.quad_en;
		p.mode = SW_PROTECTED;
		p.write_allowed = 1'b0;
		unique case ({p.protect_hi, p.protect_lo})
			2'b00: begin
				// pin has no meaning here
				p.mode = SW_PROTECTED;
				p.write_allowed = 1'b1;
			end
			2'b01: begin
				if (wp_released) begin
					p.mode = HW_UNPROTECTED;
					p.write_allowed = 1'b1;
				end else begin
					p.mode = HW_PROTECTED;
					p.write_allowed = 1'b0;
				end
			end
			2'b10: begin
				p.mode = RESET_LOCKDOWN;
				p.write_allowed = 1'b0;
			end
			2'b11: begin
				// lock decides between lockdown and permanent protection
				p.mode = p.perm_lock ? OTP_LOCKED : RESET_LOCKDOWN;
				p.write_allowed = 1'b0;
			end
		endcase
	end

endmodule

// >>> verif/srwp_assertions.sv
// Purpose: port checks of the status protect block
// Assumes: one clock, synchronous active-high rst
// Notes:   bound to the top module after endmodule
`timescale 1ns/1ps
`include "sr_params.svh"
module srwp_assertions (
	// clock, reset and inputs
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       soft_reset,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] cmd_data,
	input wire logic       write_enable_latch,
	input wire logic       nv_protect_hi,
	input wire logic       nv_protect_lo,
	input wire logic       protect_perm_lock,
	// outputs
	input wire logic [7:0] cfg_read,
	input wire logic       reg_protect_hi,
	input wire logic       reg_protect_lo,
	input wire logic       quad_io_enable,
	input wire logic       execute_in_place_mode,
	input wire logic       io2_is_data,
	input wire logic       wp_func_active,
	input wire logic       hold_func_active,
	input wire logic       reset_func_active,
	input wire logic       pin_reset_request,
	input wire logic       status_write_allowed,
	input wire logic       wr_accept,
	input wire logic       wr_reject,
	input wire logic       quad_reject,
	input wire logic       start_write_cycle
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// a reset in the same cycle drops the command, so only quiet commands count
	logic quiet;
	logic wr_op;
	logic q_op;
	assign quiet = cmd_valid && !soft_reset && !pin_reset_request;
	assign wr_op = cmd_opcode inside {`OP_WRITE_SR1, `OP_WRITE_CFG, `OP_WRITE_SR3, `OP_WRITE_SR_ALT};
	assign q_op  = cmd_opcode inside {`OP_QUAD_OUT_READ, `OP_XIP_READ, `OP_QUAD_ALIGN_READ,
		`OP_QUAD_PROGRAM, `OP_BURST_WRAP, `OP_QUAD_ID};
	a_quad_outputs: assert property (
		execute_in_place_mode == quad_io_enable && io2_is_data == quad_io_enable
		&& wp_func_active != quad_io_enable) else $error("quad mode outputs disagree");
	a_cfg_layout: assert property (
		cfg_read == {6'h00, quad_io_enable, reg_protect_hi}) else $error("cfg layout wrong");
	a_quad_gate: assert property (
		quiet |=> quad_reject == ($past(q_op) && !$past(quad_io_enable)))
		else $error("quad gate wrong");
	a_sw_accept: assert property (
		quiet && wr_op && write_enable_latch && !reg_protect_hi && !reg_protect_lo
		|=> wr_accept && start_write_cycle) else $error("open write refused");
	a_refused_write: assert property (
		quiet && wr_op && !(status_write_allowed && write_enable_latch) |=> wr_reject
		&& !start_write_cycle && $stable(cfg_read) && $stable(reg_protect_lo))
		else $error("refused write had effect");
	a_cfg_write: assert property (
		quiet && cmd_opcode == `OP_WRITE_CFG && write_enable_latch && status_write_allowed
		|=> quad_io_enable == $past(cmd_data[1]) && reg_protect_hi == $past(cmd_data[0]))
		else $error("cfg write lost");
	a_lock_states: assert property (
		reg_protect_hi |-> !status_write_allowed) else $error("locked state writable");
	a_soft_reload: assert property (
		soft_reset |=> !quad_io_enable && reg_protect_lo == $past(nv_protect_lo)
		&& reg_protect_hi == ($past(nv_protect_hi) && $past(nv_protect_lo)
		&& $past(protect_perm_lock))) else $error("reload value wrong");
	a_pin_select: assert property (
		quad_io_enable |-> !hold_func_active && !reset_func_active)
		else $error("pin function active in quad");
	c_accept: cover property (wr_accept);
	c_reject: cover property (wr_reject);
	c_quad_rej: cover property (quad_reject);
	c_otp: cover property (soft_reset ##1 reg_protect_hi);
endmodule

bind status_reg_write_protect srwp_assertions chk (.core_clk, .rst, .soft_reset, .cmd_valid,
	.cmd_opcode, .cmd_data, .write_enable_latch, .nv_protect_hi, .nv_protect_lo,
	.protect_perm_lock, .cfg_read, .reg_protect_hi, .reg_protect_lo, .quad_io_enable,
	.execute_in_place_mode, .io2_is_data, .wp_func_active, .hold_func_active,
	.reset_func_active, .pin_reset_request, .status_write_allowed, .wr_accept, .wr_reject,
	.quad_reject, .start_write_cycle);

// >>> verif/host_model.sv
// Purpose: host controller issuing decoded commands
// Assumes: inputs of the block change at the falling edge
// Notes:   released fields carry the inverse of the last value
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic  core_clk,
	// command towards the block
	output logic       cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [7:0] cmd_data
);
	// idle at time zero
	initial begin
		cmd_valid  = 1'h0;
		cmd_opcode = 8'h00;
		cmd_data   = 8'h00;
	end
	// one-cycle command; scrambled after so stale fields cannot pass for valid ones
	task automatic send(input logic [7:0] op, input logic [7:0] d);
		@(negedge core_clk);
		cmd_valid  = 1'h1;
		cmd_opcode = op;
		cmd_data   = d;
		@(negedge core_clk);
		cmd_valid  = 1'h0;
		cmd_opcode = ~op;
		cmd_data   = ~d;
	endtask
endmodule

// >>> verif/tb.sv
// Purpose: self-checking bench of the status protect block
// Assumes: pulses show just after the taking edge and are checked at the next falling edge
// Notes:   pins need four edges to pass the synchroniser
`timescale 1ns/1ps
`include "sr_params.svh"
module tb;
	import sr_pkg::*;
	// stimulus
	logic core_clk = 1'h0, rst = 1'h1, soft_reset = 1'h0, write_enable_latch = 1'h1;
	logic nv_protect_hi = 1'h0, nv_protect_lo = 1'h0, protect_perm_lock = 1'h0;
	logic hold_reset_select = 1'h0, wp_pin = 1'h1, hold_reset_pin = 1'h1;
	// observed
	logic [7:0] cmd_opcode, cmd_data, cfg_read;
	logic cmd_valid, reg_protect_hi, reg_protect_lo, quad_io_enable, execute_in_place_mode;
	logic io2_is_data, io3_is_data, wp_func_active, hold_func_active, reset_func_active;
	logic hold_request, pin_reset_request, status_write_allowed, wr_accept, wr_reject;
	logic quad_reject, start_write_cycle;
	prot_mode_type protect_mode;
	int num_errors = 0;
	int cmp_count  = 0;
	always #50 core_clk = ~core_clk;
	host_model host (.core_clk, .cmd_valid, .cmd_opcode, .cmd_data);
	status_reg_write_protect uut (.core_clk, .rst, .soft_reset, .cmd_valid, .cmd_opcode,
		.cmd_data, .write_enable_latch, .nv_protect_hi, .nv_protect_lo, .protect_perm_lock,
		.hold_reset_select, .wp_pin, .hold_reset_pin, .cfg_read, .reg_protect_hi,
		.reg_protect_lo, .quad_io_enable, .execute_in_place_mode, .io2_is_data, .io3_is_data,
		.wp_func_active, .hold_func_active, .reset_func_active, .hold_request,
		.pin_reset_request, .status_write_allowed, .protect_mode, .wr_accept, .wr_reject,
		.quad_reject, .start_write_cycle);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// pulses packed as accept, reject, quad refuse, write start
	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic [3:0] exp);
		host.send(op, d);
		check("pulses", {4'h0, wr_accept, wr_reject, quad_reject, start_write_cycle}, {4'h0, exp});
	endtask
	// software reset, or hardware reset when hw is set, with non-volatile copies {hi, lo, lock}
	task automatic reload(input logic [2:0] nv, input logic [1:0] exp, input logic hw = 1'h0);
		@(negedge core_clk);
		{nv_protect_hi, nv_protect_lo, protect_perm_lock} = nv;
		if (hw) begin
			rst = 1'h1;
		end else begin
			soft_reset = 1'h1;
		end
		@(negedge core_clk);
		rst = 1'h0;
		soft_reset = 1'h0;
		check("protect", {6'h00, reg_protect_hi, reg_protect_lo}, {6'h00, exp});
	endtask
	task automatic set_wp(input logic v);
		@(negedge core_clk);
		wp_pin = v;
		repeat (4) @(negedge core_clk);
	endtask
	task automatic t_quad;
		logic [7:0] qops [6];
		qops = '{`OP_QUAD_OUT_READ, `OP_XIP_READ, `OP_QUAD_ALIGN_READ, `OP_QUAD_PROGRAM,
			`OP_BURST_WRAP, `OP_QUAD_ID};
		check("cfg", cfg_read, 8'h00);
		check("pins", {7'h00, wp_func_active}, 8'h01);
		foreach (qops[i]) cmd(qops[i], 8'h00, 4'h2);
		cmd(8'h03, 8'h00, 4'h0);
		cmd(`OP_WRITE_SR3, 8'hFF, 4'h9);
		cmd(`OP_WRITE_SR_ALT, 8'hFF, 4'h9);
		check("cfg", cfg_read, 8'h00);
		hold_reset_select = 1'h1;
		cmd(`OP_WRITE_CFG, 8'h02, 4'h9);
		check("quad", {quad_io_enable, execute_in_place_mode, io2_is_data, io3_is_data,
			wp_func_active, hold_func_active, reset_func_active}, 8'h78);
		foreach (qops[i]) cmd(qops[i], 8'h00, 4'h0);
		cmd(`OP_WRITE_CFG, 8'h00, 4'h9);
		check("sel", {hold_func_active, reset_func_active}, 8'h01);
	endtask
	task automatic t_hw;
		cmd(`OP_WRITE_SR1, 8'h80, 4'h9);
		set_wp(1'h0);
		cmd(`OP_WRITE_CFG, 8'h01, 4'h4);
		check("cfg", {reg_protect_lo, cfg_read[6:0]}, 8'h80);
		set_wp(1'h1);
		write_enable_latch = 1'h0;
		cmd(`OP_WRITE_CFG, 8'h01, 4'h4);
		write_enable_latch = 1'h1;
		cmd(`OP_WRITE_CFG, 8'h01, 4'h9);
		cmd(`OP_WRITE_SR1, 8'h00, 4'h4);
		reload(3'h6, 2'h1);
	endtask
	task automatic t_reload;
		logic [4:0] tab [5];
		tab = '{5'h00, 5'h09, 5'h10, 5'h19, 5'h1F};
		reload(3'h0, 2'h0);
		cmd(`OP_WRITE_CFG, 8'h01, 4'h9);
		cmd(`OP_WRITE_CFG, 8'h00, 4'h4);
		foreach (tab[i]) reload(tab[i][4:2], tab[i][1:0]);
		cmd(`OP_WRITE_CFG, 8'h00, 4'h4);
		cmd(`OP_WRITE_SR3, 8'h00, 4'h4);
		cmd(`OP_WRITE_SR_ALT, 8'h00, 4'h4);
		reload(3'h7, 2'h3);
	endtask
	// mid-run hardware resets reload like the software one and clear quad mode
	task automatic t_hwreset;
		reload(3'h6, 2'h1, 1'h1);
		check("mode", {5'h00, protect_mode}, {5'h00, HW_UNPROTECTED});
		cmd(`OP_WRITE_CFG, 8'h03, 4'h9);
		check("mode", {5'h00, protect_mode}, {5'h00, RESET_LOCKDOWN});
		reload(3'h4, 2'h0, 1'h1);
		check("hw quad", {7'h00, quad_io_enable}, 8'h00);
		check("mode", {5'h00, protect_mode}, {5'h00, SW_PROTECTED});
		reload(3'h7, 2'h3, 1'h1);
		check("mode", {5'h00, protect_mode}, {5'h00, OTP_LOCKED});
	endtask
	// pause and reset functions of the shared pin, and the pin reset reload
	task automatic t_pins;
		reload(3'h0, 2'h0);
		hold_reset_select = 1'h0;
		hold_reset_pin = 1'h0;
		set_wp(1'h1);
		check("pause", {hold_request, pin_reset_request}, 8'h02);
		cmd(`OP_WRITE_CFG, 8'h02, 4'h9);
		cmd(`OP_WRITE_SR1, 8'h80, 4'h9);
		hold_reset_select = 1'h1;
		set_wp(1'h0);
		check("quad pins", {hold_request, pin_reset_request, status_write_allowed}, 8'h01);
		check("mode", {5'h00, protect_mode}, {5'h00, HW_UNPROTECTED});
		cmd(`OP_WRITE_CFG, 8'h00, 4'h9);
		check("reset pin", {pin_reset_request, status_write_allowed}, 8'h02);
		cmd(`OP_WRITE_SR1, 8'h00, 4'h0);
		check("pin reload", {6'h00, reg_protect_hi, reg_protect_lo}, 8'h00);
		hold_reset_pin = 1'h1;
		set_wp(1'h1);
		check("released", {hold_request, pin_reset_request}, 8'h00);
	endtask
	initial begin
		repeat (8) @(negedge core_clk);
		rst = 1'h0;
		t_quad();
		t_hw();
		t_reload();
		t_hwreset();
		t_pins();
		give_verdict();
	end
endmodule
